/* rtl/oce_out_stage.sv */
// Functional notes
// - Six dividers; pairs 2/3, 4/5 share one
// - Single-stage dividers are twenty bits wide
// - First/last channel: 11-bit times 20-bit cascade
// - Each divider powers down by configuration
// - Auto power-down; shared needs both drivers off
// - Driver type codes select differential or off
// - Single-ended codes set each pin independently
// - Unpowered channel idle, others unaffected
// - Auto-mute squelches on invalid selected source
// - Loop source validity follows qualified lock
// - Crystal or oscillator bypass invalid on LOSS_OF_SIGNAL
// - Differential mute: common, high or low
// - Single-ended mute forces each pin low or floating independently
// - Both mute fields zero bypasses muting
// - Loop outputs start clean after lock
// - Clean start after supply, powerdown, sync
// - Sync holds enabled dividers reset and muted
module oce_out_stage
    import oce_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    // Loop and input status
    input wire logic [1:0] ANALOG_LOCK,
    input wire logic [1:0] DIGITAL_LOCK,
    input wire logic [1:0] OSC_LOCK,
    input wire logic XO_LOS,
    input wire logic TCXO_LOS,
    // Device pins
    input wire logic HARD_PDN_N,
    input wire logic SYNC_N,
    input wire logic [NUM_CH-1:0] SUPPLY_GOOD,
    // Output drivers
    output logic [NUM_OUT-1:0] OUT_P,
    output logic [NUM_OUT-1:0] OUT_P_OE,
    output logic [NUM_OUT-1:0] OUT_N,
    output logic [NUM_OUT-1:0] OUT_N_OE,
    output logic [NUM_OUT-1:0] OUT_CM
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [G_MSB:0] glob;
    logic [G_MSB:0] next_glob;
    logic [C_MSB:0] ch_cfg [NUM_CH];
    logic [C_MSB:0] next_ch_cfg [NUM_CH];
    logic [UP_DIV_W-1:0] up_div [2];
    logic [UP_DIV_W-1:0] next_up_div [2];
    logic [7:0] out_type [NUM_OUT];
    logic [7:0] next_out_type [NUM_OUT];
    logic [DATA_W-1:0] next_rdata;

    // Channel state
    logic [NUM_CH-1:0] lvl;
    logic [NUM_CH-1:0] muted;
    logic [NUM_CH-1:0] next_muted;
    logic [NUM_CH-1:0] hold;
    logic [NUM_CH-1:0] next_hold;
    logic [NUM_CH-1:0] pwr;
    logic [NUM_CH-1:0] drv_on;
    logic [NUM_CH-1:0] invalid;
    logic [NUM_CH-1:0] clr;
    logic [1:0] up_wrap;
    logic sync_act;
    logic dev_off;

    always_comb begin
        next_glob = glob;
        next_ch_cfg = ch_cfg;
        next_up_div = up_div;
        next_out_type = out_type;
        next_rdata = '0;
        if (WR) begin
            if (ADDR == GLOBAL_OFS) begin
                next_glob = WDATA[G_MSB:0];
            end
            if (ADDR == UP_DIV0_OFS) begin
                next_up_div[0] = WDATA[UP_DIV_W-1:0];
            end
            if (ADDR == UP_DIV5_OFS) begin
                next_up_div[1] = WDATA[UP_DIV_W-1:0];
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (ADDR == CH_CFG_OFS + 8'(4 * i)) begin
                    next_ch_cfg[i] = WDATA[C_MSB:0];
                end
            end
            for (int k = 0; k < NUM_OUT; k++) begin
                if (ADDR == OUT_TYPE_OFS + 8'(4 * k)) begin
                    next_out_type[k] = WDATA[7:0];
                end
            end
        end
        // Unmapped reads answer zero
        if (RD) begin
            if (ADDR == GLOBAL_OFS) begin
                next_rdata = DATA_W'(glob);
            end
            if (ADDR == STATUS_OFS) begin
                next_rdata = {8'h00, 2'b00, invalid, 2'b00, muted, 2'b00, pwr};
            end
            if (ADDR == UP_DIV0_OFS) begin
                next_rdata = DATA_W'(up_div[0]);
            end
            if (ADDR == UP_DIV5_OFS) begin
                next_rdata = DATA_W'(up_div[1]);
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (ADDR == CH_CFG_OFS + 8'(4 * i)) begin
                    next_rdata = DATA_W'(ch_cfg[i]);
                end
            end
            for (int k = 0; k < NUM_OUT; k++) begin
                if (ADDR == OUT_TYPE_OFS + 8'(4 * k)) begin
                    next_rdata = DATA_W'(out_type[k]);
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            glob <= GLOBAL_RST[G_MSB:0];
            for (int i = 0; i < NUM_CH; i++) begin
                ch_cfg[i] <= CH_CFG_RST[C_MSB:0];
            end
            up_div[0] <= UP_DIV_RST;
            up_div[1] <= UP_DIV_RST;
            for (int k = 0; k < NUM_OUT; k++) begin
                out_type[k] <= TYPE_OFF;
            end
            RDATA <= '0;
        end else begin
            glob <= next_glob;
            ch_cfg <= next_ch_cfg;
            up_div <= next_up_div;
            out_type <= next_out_type;
            RDATA <= next_rdata;
        end
    end

    // ****************************************************************
    // Source validity, power and sync
    // ****************************************************************
    function automatic logic drv_en(input logic [7:0] t);
        drv_en = (t != TYPE_OFF);
    endfunction : drv_en

    function automatic logic loop_bad(input logic [2:0] q, input logic a,
                                      input logic d, input logic o, input logic hard_powerdown_pin);
        // A powered-down loop is never lock, so its outputs stay muted where auto-mute is on
        loop_bad = hard_powerdown_pin || (q[0] && !a) || (q[1] && !d) || (q[2] && !o);
    endfunction : loop_bad

    always_comb begin
        dev_off = !HARD_PDN_N || glob[G_SWRST];
        sync_act = !SYNC_N || glob[G_SYNC_SW];
        // Shared dividers stay up while either driver is on
        drv_on[0] = drv_en(out_type[0]);
        drv_on[1] = drv_en(out_type[1]);
        drv_on[2] = drv_en(out_type[2]) || drv_en(out_type[3]);
        drv_on[3] = drv_en(out_type[4]) || drv_en(out_type[5]);
        drv_on[4] = drv_en(out_type[6]);
        drv_on[5] = drv_en(out_type[7]);
        for (int i = 0; i < NUM_CH; i++) begin
            pwr[i] = drv_on[i] && !ch_cfg[i][C_PDN] && SUPPLY_GOOD[i] && !dev_off;
            case (oce_src_t'(ch_cfg[i][C_SRC +: 2]))
                SRC_LOOP1: invalid[i] = loop_bad(glob[G_QUAL1 +: 3], ANALOG_LOCK[0],
                    DIGITAL_LOCK[0], OSC_LOCK[0], glob[G_LOOP_PDN]);
                SRC_LOOP2: invalid[i] = loop_bad(glob[G_QUAL2 +: 3], ANALOG_LOCK[1],
                    DIGITAL_LOCK[1], OSC_LOCK[1], glob[G_LOOP_PDN + 1]);
                SRC_XO: invalid[i] = XO_LOS;
                SRC_TCXO: invalid[i] = TCXO_LOS;
                default: invalid[i] = 1'b1;
            endcase
            // Hold starts only once the divider is low: no short last period
            if (ch_cfg[i][C_SYNC_EN] && sync_act) begin
                next_hold[i] = hold[i] || !lvl[i];
            end else begin
                next_hold[i] = 1'b0;
            end
            clr[i] = hold[i] || !pwr[i];
            // Both mute fields zero means no mute at all
            if (!ch_cfg[i][C_AMUTE] && ch_cfg[i][C_LVL +: 2] == 2'b00) begin
                next_muted[i] = 1'b0;
            end else if (!lvl[i]) begin
                next_muted[i] = (ch_cfg[i][C_AMUTE] && invalid[i])
                    || !pwr[i]
                    || (ch_cfg[i][C_SYNC_EN] && glob[G_SYNC_MUTE] && sync_act);
            end else begin
                next_muted[i] = muted[i];
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            hold <= '0;
            muted <= '1;
        end else begin
            hold <= next_hold;
            muted <= next_muted;
        end
    end

    // ****************************************************************
    // Dividers
    // ****************************************************************
    // Cascaded stages on the first and last channel
    oce_div #(.W(UP_DIV_W)) u_up0 (
        .clk(CLK), .rst_n(RST_N), .clr(clr[0]), .adv(1'b1),
        .div(up_div[0]), .level(), .wrap(up_wrap[0])
    );
    oce_div #(.W(UP_DIV_W)) u_up5 (
        .clk(CLK), .rst_n(RST_N), .clr(clr[5]), .adv(1'b1),
        .div(up_div[1]), .level(), .wrap(up_wrap[1])
    );

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        logic adv;
        // Lower stage steps once per upper-stage wrap: product of both
        assign adv = (g == 0) ? up_wrap[0] : (g == 5) ? up_wrap[1] : 1'b1;
        oce_div #(.W(LOW_DIV_W)) u_div (
            .clk(CLK), .rst_n(RST_N), .clr(clr[g]), .adv(adv),
            .div(ch_cfg[g][LOW_DIV_W-1:0]), .level(lvl[g]), .wrap()
        );
    end

    // ****************************************************************
    // Drivers
    // ****************************************************************
    function automatic logic [2:0] ch_of(input int k);
        case (k)
            0: ch_of = 3'd0;
            1: ch_of = 3'd1;
            2, 3: ch_of = 3'd2;
            4, 5: ch_of = 3'd3;
            6: ch_of = 3'd4;
            default: ch_of = 3'd5;
        endcase
    endfunction : ch_of

    // Pin code: 0 HiZ, 1 low, 2 inverted, 3 true
    function automatic logic [1:0] pin_drv(input logic [1:0] code, input logic c);
        case (code)
            PIN_LOW: pin_drv = 2'b10;
            PIN_INV: pin_drv = {1'b1, !c};
            PIN_TRUE: pin_drv = {1'b1, c};
            default: pin_drv = 2'b00;
        endcase
    endfunction : pin_drv

    always_comb begin
        logic [2:0] c;
        logic [7:0] t;
        logic [1:0] ml;
        logic [1:0] pp;
        logic [1:0] pn;
        c = '0;
        t = '0;
        ml = '0;
        pp = '0;
        pn = '0;
        for (int k = 0; k < NUM_OUT; k++) begin
            c = ch_of(k);
            t = out_type[k];
            ml = ch_cfg[c][C_LVL +: 2];
            OUT_P[k] = 1'b0;
            OUT_N[k] = 1'b0;
            OUT_P_OE[k] = 1'b0;
            OUT_N_OE[k] = 1'b0;
            OUT_CM[k] = 1'b0;
            if (!pwr[c]) begin
                OUT_P_OE[k] = 1'b0;
            end else if (t == TYPE_LVDS || t == TYPE_CML || t == TYPE_PECL
                         || t == TYPE_HCSL_EXT || t == TYPE_HCSL_INT) begin
                OUT_P_OE[k] = 1'b1;
                OUT_N_OE[k] = 1'b1;
                if (!muted[c]) begin
                    OUT_P[k] = lvl[c];
                    OUT_N[k] = !lvl[c];
                end else if (ml == LVL_DIFF_HI) begin
                    OUT_P[k] = 1'b1;
                end else if (ml == LVL_DIFF_LO) begin
                    OUT_N[k] = 1'b1;
                end else begin
                    OUT_P_OE[k] = 1'b0;
                    OUT_N_OE[k] = 1'b0;
                    OUT_CM[k] = 1'b1;
                end
            end else if (t[7:4] == TYPE_SE_HI) begin
                pp = pin_drv(t[3:2], lvl[c]);
                pn = pin_drv(t[1:0], lvl[c]);
                // Muted pin without its low bit set floats
                if (muted[c]) begin
                    pp = ml[0] ? 2'b10 : 2'b00;
                    pn = ml[1] ? 2'b10 : 2'b00;
                end
                OUT_P_OE[k] = pp[1];
                OUT_P[k] = pp[0];
                OUT_N_OE[k] = pn[1];
                OUT_N[k] = pn[0];
            end
        end
    end
endmodule : oce_out_stage

/* rtl/oce_pkg.sv */
package oce_pkg;
    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_CH = 6;
    localparam int NUM_OUT = 8;
    localparam int LOW_DIV_W = 20;
    localparam int UP_DIV_W = 11;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] GLOBAL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CH_CFG_OFS = 8'h10;
    localparam logic [7:0] UP_DIV0_OFS = 8'h30;
    localparam logic [7:0] UP_DIV5_OFS = 8'h34;
    localparam logic [7:0] OUT_TYPE_OFS = 8'h40;

    // ****************************************************************
    // Global register fields
    // ****************************************************************
    localparam int G_SWRST = 0;
    localparam int G_LOOP_PDN = 1;
    localparam int G_SYNC_SW = 3;
    localparam int G_SYNC_MUTE = 4;
    localparam int G_QUAL1 = 5;
    localparam int G_QUAL2 = 8;
    localparam int G_MSB = 10;
    localparam logic [31:0] GLOBAL_RST = 32'h0000_07F0;

    // ****************************************************************
    // Channel configuration fields
    // ****************************************************************
    localparam int C_PDN = 20;
    localparam int C_AMUTE = 21;
    localparam int C_LVL = 22;
    localparam int C_SYNC_EN = 24;
    localparam int C_SRC = 25;
    localparam int C_MSB = 26;
    localparam logic [31:0] CH_CFG_RST = 32'h0020_0004;
    localparam logic [10:0] UP_DIV_RST = 11'h001;

    // ****************************************************************
    // Sources and driver codes
    // ****************************************************************
    typedef enum logic [1:0] {
        SRC_LOOP1 = 2'h0,
        SRC_LOOP2 = 2'h1,
        SRC_XO = 2'h2,
        SRC_TCXO = 2'h3
    } oce_src_t;

    localparam logic [7:0] TYPE_OFF = 8'h00;
    localparam logic [7:0] TYPE_LVDS = 8'h10;
    localparam logic [7:0] TYPE_CML = 8'h14;
    localparam logic [7:0] TYPE_PECL = 8'h18;
    localparam logic [7:0] TYPE_HCSL_EXT = 8'h2C;
    localparam logic [7:0] TYPE_HCSL_INT = 8'h2D;
    localparam logic [3:0] TYPE_SE_HI = 4'h3;
    localparam logic [1:0] PIN_HIZ = 2'h0;
    localparam logic [1:0] PIN_LOW = 2'h1;
    localparam logic [1:0] PIN_INV = 2'h2;
    localparam logic [1:0] PIN_TRUE = 2'h3;
    localparam logic [1:0] LVL_DIFF_HI = 2'h1;
    localparam logic [1:0] LVL_DIFF_LO = 2'h2;
endpackage : oce_pkg

/* rtl/oce_div.sv */
module oce_div
    import oce_pkg::*;
#(
    parameter int W = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic adv,
    input wire logic [W-1:0] div,
    // Result
    output logic level,
    output logic wrap
);
    logic [W-1:0] cnt;
    logic [W-1:0] n;
    logic [W-1:0] next_cnt;
    logic next_level;

    // Values below two act as two: no pass-through
    always_comb begin
        n = (div < W'(2)) ? W'(2) : div;
        // Wrap at or past the end: a smaller divide value takes hold at once
        wrap = adv && (cnt >= n - W'(1));
        if (clr) begin
            next_cnt = '0;
        end else if (wrap) begin
            next_cnt = '0;
        end else if (adv) begin
            next_cnt = cnt + W'(1);
        end else begin
            next_cnt = cnt;
        end
        // Low first half so a released divider starts on a clean low
        next_level = !clr && (next_cnt >= (n >> 1));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            level <= 1'b0;
        end else begin
            cnt <= next_cnt;
            level <= next_level;
        end
    end
endmodule : oce_div

/* test/oce_out_stage_monitor.sv */
module oce_out_stage_monitor
    import oce_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic RD,
    input wire logic [DATA_W-1:0] RDATA,
    // Pins
    input wire logic HARD_PDN_N,
    input wire logic [NUM_CH-1:0] SUPPLY_GOOD,
    // Drivers
    input wire logic [NUM_OUT-1:0] OUT_P_OE,
    input wire logic [NUM_OUT-1:0] OUT_N_OE,
    input wire logic [NUM_OUT-1:0] OUT_CM
);
    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_rd_at(logic [7:0] a);
        RD && ADDR == a;
    endsequence
    // Slack of three cycles
    sequence s_pdn_held;
        !HARD_PDN_N [*3];
    endsequence
    property p_rd_idle;
        !$past(RD) |-> RDATA == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
    property p_rd_unmapped;
        s_rd_at(8'hF0) |=> RDATA == 32'h0000_0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_status_fields;
        s_rd_at(STATUS_OFS) |=> (RDATA & 32'hFFC0_C0C0) == 32'h0000_0000;
    endproperty
    a_status_fields: assert property (p_status_fields) else $error("status spare bits set");
    property p_global_fields;
        s_rd_at(GLOBAL_OFS) |=> RDATA[31:11] == 21'h00_0000;
    endproperty
    a_global_fields: assert property (p_global_fields) else $error("global spare bits set");
    property p_cm_quiet;
        (OUT_CM & (OUT_P_OE | OUT_N_OE)) == 8'h00;
    endproperty
    a_cm_quiet: assert property (p_cm_quiet) else $error("common mode while driven");
    property p_hard_off;
        s_pdn_held |-> (OUT_P_OE | OUT_N_OE) == 8'h00;
    endproperty
    a_hard_off: assert property (p_hard_off) else $error("pin driven in powerdown");
    property p_pdn_status;
        s_pdn_held ##0 s_rd_at(STATUS_OFS) |=> RDATA[5:0] == 6'h00;
    endproperty
    a_pdn_status: assert property (p_pdn_status) else $error("channel powered in pdn");
    property p_supply_off;
        !SUPPLY_GOOD[1] [*3] |-> !OUT_P_OE[1] && !OUT_N_OE[1];
    endproperty
    a_supply_off: assert property (p_supply_off) else $error("driven without supply");
    property p_shared_off;
        !SUPPLY_GOOD[2] [*3] |-> OUT_P_OE[3:2] == 2'h0 && OUT_N_OE[3:2] == 2'h0;
    endproperty
    a_shared_off: assert property (p_shared_off) else $error("shared pair driven");
endmodule : oce_out_stage_monitor

/* test/oce_rx_model.sv */
module oce_rx_model
    import oce_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Driver pins
    input wire logic [NUM_OUT-1:0] pin,
    input wire logic [NUM_OUT-1:0] pin_oe,
    // Receiver view
    output logic [NUM_OUT-1:0] level,
    output logic [NUM_OUT-1:0][15:0] period
);
    // ****************************************************************
    // Receivers
    // ****************************************************************
    logic [NUM_OUT-1:0] last;
    logic [NUM_OUT-1:0][15:0] cnt;
    logic [NUM_OUT-1:0][15:0] next_cnt;
    logic [NUM_OUT-1:0][15:0] next_period;
    // Released pin flips each cycle, so a stale level never looks valid
    assign level = (pin & pin_oe) | (~last & ~pin_oe);
    always_comb begin
        next_cnt = cnt;
        next_period = period;
        for (int k = 0; k < NUM_OUT; k++) begin
            next_cnt[k] = cnt[k] + 16'h0001;
            if (level[k] && !last[k]) begin
                next_period[k] = next_cnt[k];
                next_cnt[k] = 16'h0000;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last <= '0;
            cnt <= '0;
            period <= '0;
        end else begin
            last <= level;
            cnt <= next_cnt;
            period <= next_period;
        end
    end
endmodule : oce_rx_model

/* test/tb_top.sv */
bind oce_out_stage oce_out_stage_monitor oce_out_stage_monitor_inst (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .HARD_PDN_N(HARD_PDN_N),
    .SUPPLY_GOOD(SUPPLY_GOOD), .OUT_P_OE(OUT_P_OE), .OUT_N_OE(OUT_N_OE), .OUT_CM(OUT_CM)
);
module tb_top
    import oce_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Bench
    // ****************************************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [1:0] a_lock = 2'h3;
    logic [1:0] d_lock = 2'h3;
    logic [1:0] o_lock = 2'h3;
    logic xo_los = 1'b0;
    logic tcxo_los = 1'b0;
    logic hard_pdn_n = 1'b1;
    logic sync_n = 1'b1;
    logic [5:0] supply = 6'h3F;
    logic [7:0] p, p_oe, n, n_oe, cm;
    logic [7:0][15:0] period;
    logic [7:0] codes [7] = '{TYPE_OFF, TYPE_LVDS, TYPE_CML, TYPE_PECL, TYPE_HCSL_EXT,
        TYPE_HCSL_INT, 8'h20};
    int errors = 0;
    int comparisons = 0;
    int seed;
    int dv;
    always #20 clk = ~clk;
    oce_out_stage oce_out_stage_inst (
        .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .ANALOG_LOCK(a_lock), .DIGITAL_LOCK(d_lock), .OSC_LOCK(o_lock),
        .XO_LOS(xo_los), .TCXO_LOS(tcxo_los), .HARD_PDN_N(hard_pdn_n), .SYNC_N(sync_n),
        .SUPPLY_GOOD(supply), .OUT_P(p), .OUT_P_OE(p_oe), .OUT_N(n), .OUT_N_OE(n_oe),
        .OUT_CM(cm)
    );
    oce_rx_model oce_rx_model_inst (
        .clk(clk), .rst_n(rst_n), .pin(p), .pin_oe(p_oe), .level(), .period(period)
    );
    function automatic int eff(input int v);
        return (v < 2) ? 2 : v;
    endfunction : eff
    function automatic logic [31:0] cfg(input int d, input bit pd, input bit am,
        input logic [1:0] lv, input bit sy, input logic [1:0] src);
        return {5'h00, src, sy, lv, am, pd, d[19:0]};
    endfunction : cfg
    function automatic logic [2:0] mute_pins(input int lv);
        return (lv == 1) ? 3'h2 : (lv == 2) ? 3'h1 : 3'h4;
    endfunction : mute_pins
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
    endtask : rd
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        check(nm, rdata, e);
    endtask : rd_chk
    task automatic st_chk(input string nm, input int b, input bit e);
        rd(STATUS_OFS);
        check(nm, rdata[b], e);
    endtask : st_chk
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : idle
    // Three periods flush a partial first one
    task automatic per_chk(input string nm, input int k, input int e);
        idle(3 * e + 8);
        check(nm, period[k], e);
    endtask : per_chk
    initial begin
        #1_000_000;
        errors++;
        tally_and_finish();
    end
    initial begin
        seed = $urandom(32'h93c6585b);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("global", GLOBAL_OFS, GLOBAL_RST);
        for (int i = 0; i < NUM_CH; i++) begin
            rd_chk("cfg", CH_CFG_OFS + 8'(4 * i), CH_CFG_RST);
            rd_chk("type", OUT_TYPE_OFS + 8'(4 * i), 32'h0000_0000);
        end
        rd_chk("updiv", UP_DIV5_OFS, 32'(UP_DIV_RST));
        wr(8'hF0, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'hF0, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            wr(OUT_TYPE_OFS + 8'h04, codes[i]);
            idle(12);
            st_chk("type_pwr", 1, i != 0);
            check("type_oe", {p_oe[1], n_oe[1]}, (i % 6) ? 2'h3 : 2'h0);
        end
        wr(OUT_TYPE_OFS + 8'h04, TYPE_LVDS);
        per_chk("div_rst", 1, 4);
        check("pair", n[1], !p[1]);
        for (int i = 0; i < 6; i++) begin
            dv = (i < 2) ? i : 2 + int'($urandom % 40);
            wr(CH_CFG_OFS + 8'h04, cfg(dv, 0, 1, 2'h0, 0, SRC_LOOP1));
            per_chk("div", 1, eff(dv));
        end
        wr(CH_CFG_OFS + 8'h04, cfg(4, 0, 1, 2'h0, 0, SRC_LOOP1));
        wr(OUT_TYPE_OFS, TYPE_LVDS);
        wr(UP_DIV0_OFS, 32'h0000_0003);
        wr(CH_CFG_OFS, cfg(5, 0, 1, 2'h0, 0, SRC_LOOP1));
        per_chk("cascade0", 0, eff(3) * eff(5));
        wr(OUT_TYPE_OFS + 8'h1C, TYPE_LVDS);
        wr(UP_DIV5_OFS, 32'h0000_0002);
        wr(CH_CFG_OFS + 8'h14, cfg(7, 0, 1, 2'h0, 0, SRC_LOOP1));
        per_chk("cascade5", 7, eff(2) * eff(7));
        for (int lv = 0; lv < 3; lv++) begin
            wr(CH_CFG_OFS + 8'h04, cfg(4, 0, 1, 2'(lv), 0, SRC_LOOP1));
            a_lock <= 2'h2;
            idle(20);
            st_chk("mute_lol", 9, 1);
            check("mute_lvl", {cm[1], p[1] & p_oe[1], n[1] & n_oe[1]}, mute_pins(lv));
            a_lock <= 2'h3;
            idle(20);
            st_chk("unmute", 9, 0);
        end
        for (int q = 0; q < 3; q++) begin
            wr(GLOBAL_OFS, GLOBAL_RST & ~(32'h1 << (G_QUAL1 + q)));
            a_lock <= (q == 0) ? 2'h2 : 2'h3;
            d_lock <= (q == 1) ? 2'h2 : 2'h1;
            o_lock <= (q == 2) ? 2'h2 : 2'h3;
            idle(20);
            st_chk("qual_off", 9, 0);
            wr(GLOBAL_OFS, GLOBAL_RST);
            idle(20);
            st_chk("qual_on", 9, 1);
        end
        {a_lock, d_lock, o_lock} <= 6'h3F;
        wr(GLOBAL_OFS, GLOBAL_RST | (32'h1 << G_LOOP_PDN));
        idle(20);
        st_chk("loop_pdn", 9, 1);
        wr(GLOBAL_OFS, GLOBAL_RST);
        idle(20);
        st_chk("loop_up", 9, 0);
        for (int s = 0; s < 2; s++) begin
            wr(CH_CFG_OFS + 8'h04, cfg(4, 0, 1, 2'h0, 0, s ? SRC_TCXO : SRC_XO));
            xo_los <= (s == 1);
            tcxo_los <= (s == 0);
            idle(20);
            st_chk("los_other", 9, 0);
            xo_los <= (s == 0);
            tcxo_los <= (s == 1);
            idle(20);
            st_chk("los", 9, 1);
        end
        xo_los <= 1'b0;
        tcxo_los <= 1'b0;
        wr(CH_CFG_OFS + 8'h04, cfg(4, 0, 1, 2'h0, 0, SRC_LOOP1));
        for (int c = 0; c < 16; c++) begin
            wr(OUT_TYPE_OFS + 8'h04, {TYPE_SE_HI, 4'(c)});
            idle(12);
            check("se_oe", {p_oe[1], n_oe[1]}, {c[3:2] != 0, c[1:0] != 0});
            if (c == 5) check("se_low", {p[1], n[1]}, 2'h0);
            if (c == 14) check("se_pair", n[1], !p[1]);
        end
        for (int lv = 1; lv < 4; lv++) begin
            wr(CH_CFG_OFS + 8'h04, cfg(4, 0, 1, 2'(lv), 0, SRC_LOOP1));
            a_lock <= 2'h2;
            idle(20);
            check("se_mute", {p_oe[1], p[1] & p_oe[1], n_oe[1], n[1] & n_oe[1]},
                {lv[0], 1'b0, lv[1], 1'b0});
            a_lock <= 2'h3;
        end
        wr(OUT_TYPE_OFS + 8'h04, TYPE_LVDS);
        wr(CH_CFG_OFS + 8'h04, cfg(4, 0, 0, 2'h0, 0, SRC_LOOP1));
        a_lock <= 2'h2;
        per_chk("bypass", 1, 4);
        st_chk("bypass_mute", 9, 0);
        a_lock <= 2'h3;
        wr(CH_CFG_OFS + 8'h04, cfg(4, 0, 1, 2'h0, 1, SRC_LOOP1));
        sync_n <= 1'b0;
        per_chk("sync_other", 0, 15);
        st_chk("sync_mute", 9, 1);
        check("sync_cm", cm[1], 1'b1);
        sync_n <= 1'b1;
        per_chk("sync_free", 1, 4);
        wr(OUT_TYPE_OFS + 8'h08, TYPE_LVDS);
        st_chk("pair_on", 2, 1);
        wr(OUT_TYPE_OFS + 8'h08, TYPE_OFF);
        wr(OUT_TYPE_OFS + 8'h0C, TYPE_LVDS);
        st_chk("pair_half", 2, 1);
        wr(OUT_TYPE_OFS + 8'h0C, TYPE_OFF);
        idle(4);
        st_chk("pair_off", 2, 0);
        wr(CH_CFG_OFS + 8'h04, cfg(4, 1, 1, 2'h0, 0, SRC_LOOP1));
        idle(4);
        st_chk("soft_pdn", 1, 0);
        per_chk("others_run", 0, 15);
        wr(CH_CFG_OFS + 8'h04, cfg(4, 0, 1, 2'h0, 0, SRC_LOOP1));
        per_chk("soft_up", 1, 4);
        supply <= 6'h39;
        idle(8);
        st_chk("supply_off", 1, 0);
        per_chk("supply_other", 7, 14);
        supply <= 6'h3F;
        per_chk("supply_up", 1, 4);
        hard_pdn_n <= 1'b0;
        idle(6);
        st_chk("hard_pdn", 0, 0);
        check("hard_oe", p_oe | n_oe, 8'h00);
        hard_pdn_n <= 1'b1;
        idle(4);
        tally_and_finish();
    end
endmodule : tb_top
